// File: core/tlpic_top.sv
// two-level priority interrupt controller with wishbone registers
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "tlpic_consts.svh"
module tlpic_top
    import tlpic_pkg::*;
(
    input wire logic clk_i,                  // instruction clock
    input wire logic rst_i,                  // synchronous reset, high
    input wire logic [7:0] wb_adr_i,         // byte address
    input wire logic [31:0] wb_dat_i,        // write data
    output logic [31:0] wb_dat_o,            // read data
    input wire logic wb_we_i,                // write enable
    input wire logic [3:0] wb_sel_i,         // byte selects
    input wire logic wb_cyc_i,               // bus cycle
    input wire logic wb_stb_i,               // strobe
    output logic wb_ack_o,                   // acknowledge
    input wire logic [2:0] ext_line_i,       // external lines a, b, c
    input wire logic [3:0] port_b_pins_i,    // upper four port pins
    input wire logic [7:0] port_b_latch_i,   // port output latch
    input wire logic timer_zero_overflow_i,  // timer-0 overflow pulse
    input wire logic periph_high_req_i,      // peripheral high request
    input wire logic periph_low_req_i,       // peripheral low request
    input wire logic return_from_isr_instr_i, // return instruction pulse
    output logic pc_load_o,                  // load vector into pc
    output logic push_return_o,              // push return address
    output logic [20:0] pc_vector_o,         // vector address
    output logic [7:0] port_pullup_en_o      // per-pin pull-up enable
);
    tlpic_byte_type main_ctl;
    tlpic_byte_type edge_pri_ctl;
    tlpic_byte_type ext_ctl;
    logic priority_levels_on;
    logic [3:0] port_last;
    logic in_high;
    logic in_low;
    logic serv_high;
    logic [1:0] lat_cnt;
    tlpic_state_type state;

    tlpic_byte_type next_main;
    tlpic_byte_type next_edge;
    tlpic_byte_type next_ext;
    tlpic_state_type next_state;
    logic [1:0] next_cnt;

    // bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    wire bus_rd = bus_req & ~wb_we_i;
    wire [7:0] wdata = wb_dat_i[7:0];
    wire sel_main = wb_adr_i == `TLPIC_OFS_MAIN;
    wire sel_edge = wb_adr_i == `TLPIC_OFS_EDGE;
    wire sel_ext = wb_adr_i == `TLPIC_OFS_EXT;
    wire sel_rctl = wb_adr_i == `TLPIC_OFS_RCTL;
    wire sel_port = wb_adr_i == `TLPIC_OFS_PORT;
    wire sel_stat = wb_adr_i == `TLPIC_OFS_STAT;
    wire wr_main = bus_wr & sel_main;
    wire wr_edge = bus_wr & sel_edge;
    wire wr_ext = bus_wr & sel_ext;
    wire wr_rctl = bus_wr & sel_rctl;
    wire rd_port = bus_rd & sel_port;

    // global enable fields
    wire global_high_enable = main_ctl[`TLPIC_MAIN_GLOBAL_HIGH];
    wire global_low_enable = main_ctl[`TLPIC_MAIN_GLOBAL_LOW];
    wire global_enable_bit = global_high_enable;
    wire peripheral_gate_enable = global_low_enable;
    wire port_pullup_disable = edge_pri_ctl[`TLPIC_EDGE_PULLUP_OFF];

    // edge detectors, index 0 = line a, 1 = line b, 2 = line c
    wire [2:0] edge_sel = {edge_pri_ctl[`TLPIC_EDGE_SEL_C],
                           edge_pri_ctl[`TLPIC_EDGE_SEL_B],
                           edge_pri_ctl[`TLPIC_EDGE_SEL_A]};
    wire [2:0] ext_event;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : gen_edge
            tlpic_edge_detect u_edge (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .line_i(ext_line_i[g]),
                .rising_sel_i(edge_sel[g]),
                .event_o(ext_event[g])
            );
        end
    endgenerate

    // mismatch stays true until software reads the port
    wire port_mismatch = port_b_pins_i != port_last;

    // sources: 0 timer, 1 line a, 2 port change, 3 line b, 4 line c
    wire [4:0] src_flag = {ext_ctl[`TLPIC_EXT_C_FLAG],
                           ext_ctl[`TLPIC_EXT_B_FLAG],
                           main_ctl[`TLPIC_MAIN_PORT_FLAG],
                           main_ctl[`TLPIC_MAIN_EXTA_FLAG],
                           main_ctl[`TLPIC_MAIN_TMR_FLAG]};
    wire [4:0] src_en = {ext_ctl[`TLPIC_EXT_C_EN],
                         ext_ctl[`TLPIC_EXT_B_EN],
                         main_ctl[`TLPIC_MAIN_PORT_EN],
                         main_ctl[`TLPIC_MAIN_EXTA_EN],
                         main_ctl[`TLPIC_MAIN_TMR_EN]};
    // line a has no priority bit and counts as high
    wire [4:0] src_pri = {ext_ctl[`TLPIC_EXT_C_PRI],
                          ext_ctl[`TLPIC_EXT_B_PRI],
                          edge_pri_ctl[`TLPIC_EDGE_PORT_PRI],
                          1'b1,
                          edge_pri_ctl[`TLPIC_EDGE_TMR_PRI]};
    wire [4:0] src_active = src_flag & src_en;

    wire high_src = (|(src_active & src_pri)) | periph_high_req_i;
    wire low_src = (|(src_active & ~src_pri)) | periph_low_req_i;

    // priority mode gating; high bit clear also masks low level
    wire take_high = global_high_enable & high_src & ~in_high;
    wire take_low = global_high_enable & global_low_enable & low_src
                    & ~in_high;

    // compatibility gating ignores priority bits
    wire periph_any = periph_high_req_i | periph_low_req_i;
    wire take_compat = global_enable_bit
                       & ((|src_active) | (peripheral_gate_enable & periph_any));

    wire want_high = priority_levels_on ? take_high : take_compat;
    wire want_low = priority_levels_on & take_low & ~take_high;
    wire is_idle = state == tlpic_idle;
    wire respond = is_idle & (want_high | want_low);
    wire return_from_isr_instr = return_from_isr_instr_i;
    wire vec_now = (state == tlpic_wait) && (lat_cnt == 2'(`TLPIC_LAT_CYCLES - 2));

    tlpic_byte_type rd_byte;
    assign rd_byte = sel_main ? main_ctl :
                     sel_edge ? edge_pri_ctl :
                     sel_ext ? ext_ctl :
                     sel_rctl ? {priority_levels_on, 7'h00} :
                     sel_port ? {port_b_pins_i, 4'h0} :
                     sel_stat ? {5'h00, serv_high, in_high, in_low} :
                     8'h00;

    always_comb
    begin
        next_main = wr_main ? wdata : main_ctl;
        if (return_from_isr_instr && in_high)
        begin
            next_main[`TLPIC_MAIN_GLOBAL_HIGH] = 1'b1;
        end
        else if (return_from_isr_instr && in_low)
        begin
            next_main[`TLPIC_MAIN_GLOBAL_LOW] = 1'b1;
        end
        // compatibility uses bit7 as the single global bit
        if (respond && want_high)
        begin
            next_main[`TLPIC_MAIN_GLOBAL_HIGH] = 1'b0;
        end
        else if (respond)
        begin
            next_main[`TLPIC_MAIN_GLOBAL_LOW] = 1'b0;
        end
        // hardware set wins over a software clear in the same cycle
        next_main[`TLPIC_MAIN_TMR_FLAG] =
            next_main[`TLPIC_MAIN_TMR_FLAG] | timer_zero_overflow_i;
        next_main[`TLPIC_MAIN_EXTA_FLAG] =
            next_main[`TLPIC_MAIN_EXTA_FLAG] | ext_event[0];
        next_main[`TLPIC_MAIN_PORT_FLAG] =
            next_main[`TLPIC_MAIN_PORT_FLAG] | port_mismatch;
    end

    always_comb
    begin
        next_edge = wr_edge ? (wdata & `TLPIC_MASK_EDGE) : edge_pri_ctl;
        next_ext = wr_ext ? (wdata & `TLPIC_MASK_EXT) : ext_ctl;
        next_ext[`TLPIC_EXT_B_FLAG] = next_ext[`TLPIC_EXT_B_FLAG] | ext_event[1];
        next_ext[`TLPIC_EXT_C_FLAG] = next_ext[`TLPIC_EXT_C_FLAG] | ext_event[2];
    end

    // fixed latency whatever the interrupted instruction length
    always_comb
    begin
        next_state = state;
        next_cnt = lat_cnt;
        case (state)
            tlpic_idle:
            begin
                next_cnt = 2'd0;
                if (respond)
                begin
                    next_state = tlpic_wait;
                end
            end
            tlpic_wait:
            begin
                next_cnt = lat_cnt + 2'd1;
                if (vec_now)
                begin
                    next_state = tlpic_vec;
                end
            end
            tlpic_vec:
            begin
                next_state = tlpic_idle;
            end
            default:
            begin
                next_state = tlpic_idle;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            main_ctl <= `TLPIC_RST_MAIN;
            edge_pri_ctl <= `TLPIC_RST_EDGE;
            ext_ctl <= `TLPIC_RST_EXT;
            priority_levels_on <= 1'b0;
        end
        else
        begin
            main_ctl <= next_main;
            edge_pri_ctl <= next_edge;
            ext_ctl <= next_ext;
            if (wr_rctl)
            begin
                priority_levels_on <= wdata[`TLPIC_RCTL_PRIO_ON];
            end
        end
    end

    // reading the port ends the mismatch
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            port_last <= 4'h0;
        end
        else if (rd_port)
        begin
            port_last <= port_b_pins_i;
        end
    end

    // service nesting: a high may stack on a low, never the reverse
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            in_high <= 1'b0;
            in_low <= 1'b0;
            serv_high <= 1'b0;
        end
        else
        begin
            if (respond)
            begin
                serv_high <= want_high;
            end
            if (respond && want_high)
            begin
                in_high <= 1'b1;
            end
            else if (return_from_isr_instr && in_high)
            begin
                in_high <= 1'b0;
            end
            if (respond && !want_high)
            begin
                in_low <= 1'b1;
            end
            else if (return_from_isr_instr && !in_high && in_low)
            begin
                in_low <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= tlpic_idle;
            lat_cnt <= 2'd0;
        end
        else
        begin
            state <= next_state;
            lat_cnt <= next_cnt;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pc_load_o <= 1'b0;
            push_return_o <= 1'b0;
            pc_vector_o <= `TLPIC_VEC_HIGH;
        end
        else
        begin
            pc_load_o <= vec_now;
            push_return_o <= vec_now;
            if (vec_now)
            begin
                pc_vector_o <= serv_high ? `TLPIC_VEC_HIGH : `TLPIC_VEC_LOW;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            port_pullup_en_o <= 8'h00;
        end
        else
        begin
            port_pullup_en_o <= port_pullup_disable ? 8'h00 : port_b_latch_i;
        end
    end

    // single-cycle ack; unmapped addresses read zero and ignore writes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            if (bus_rd)
            begin
                wb_dat_o <= {24'h000000, rd_byte};
            end
        end
    end
endmodule

// File: core/tlpic_consts.svh
// constants for the two-level priority interrupt controller
//
// Contract
// - high vector 000008h, low vector 000018h
// - pending high preempts running low routine
// - each source has flag, enable, priority; line a has no priority bit and is fixed high
// - priority mode only while priority-enable set
// - priority mode: bit7 high, bit6 low gate
// - flag, enable, global set: vector immediately
// - compatibility: bit6 peripherals, bit7 all, 000008h
// - response clears the global enable in use
// - no low interrupt during high routine
// - push return address, load vector into pc
// - return instruction re-sets cleared global enable
// - external event latency fixed, three cycles
// - flags set regardless of any enable
// - low global bit gates low peripherals
// - clearing bit7 disables all interrupts
// - port mismatch keeps flag set; read ends it
// - edge select bits 6,5,4; 1 rising
// - main control flags bits 2..0, enables 5..3
// - priority bits: ctl2 2,0; ctl3 7,6
// - ctl3 enables 4,3, flags 1,0, 5,2 zero
// - ctl2 bit7 disables all port pull-ups
// - peripheral requests join via gates
`ifndef TLPIC_CONSTS_SVH
`define TLPIC_CONSTS_SVH

// register byte addresses on the wishbone bus
`define TLPIC_OFS_MAIN 8'h00
`define TLPIC_OFS_EDGE 8'h04
`define TLPIC_OFS_EXT 8'h08
`define TLPIC_OFS_RCTL 8'h0c
`define TLPIC_OFS_PORT 8'h10
`define TLPIC_OFS_STAT 8'h14

`define TLPIC_RST_MAIN 8'h00
`define TLPIC_RST_EDGE 8'hf5
`define TLPIC_RST_EXT 8'hc0
`define TLPIC_MASK_EDGE 8'hf5
`define TLPIC_MASK_EXT 8'hdb

// main control fields
`define TLPIC_MAIN_GLOBAL_HIGH 7
`define TLPIC_MAIN_GLOBAL_LOW 6
`define TLPIC_MAIN_TMR_EN 5
`define TLPIC_MAIN_EXTA_EN 4
`define TLPIC_MAIN_PORT_EN 3
`define TLPIC_MAIN_TMR_FLAG 2
`define TLPIC_MAIN_EXTA_FLAG 1
`define TLPIC_MAIN_PORT_FLAG 0
// edge and priority control fields
`define TLPIC_EDGE_PULLUP_OFF 7
`define TLPIC_EDGE_SEL_A 6
`define TLPIC_EDGE_SEL_B 5
`define TLPIC_EDGE_SEL_C 4
`define TLPIC_EDGE_TMR_PRI 2
`define TLPIC_EDGE_PORT_PRI 0
// external line control fields
`define TLPIC_EXT_C_PRI 7
`define TLPIC_EXT_B_PRI 6
`define TLPIC_EXT_C_EN 4
`define TLPIC_EXT_B_EN 3
`define TLPIC_EXT_C_FLAG 1
`define TLPIC_EXT_B_FLAG 0
// priority-enable bit of the reset-cause control register
`define TLPIC_RCTL_PRIO_ON 7

`define TLPIC_VEC_HIGH 21'h000008
`define TLPIC_VEC_LOW 21'h000018

// latency in instruction cycles; one instruction cycle is one clk
`define TLPIC_LAT_INSTR 3
`define TLPIC_LAT_CYCLES (`TLPIC_LAT_INSTR * 1)

`endif

// File: core/tlpic_pkg.sv
// types for the two-level priority interrupt controller
package tlpic_pkg;

    typedef enum logic [1:0] {
        tlpic_idle = 2'b00,
        tlpic_wait = 2'b01,
        tlpic_vec = 2'b11
    } tlpic_state_type;

    typedef logic [7:0] tlpic_byte_type;

endpackage

// File: core/tlpic_edge_detect.sv
// selectable edge detector for one external interrupt line
`timescale 1ns/100ps
module tlpic_edge_detect (
    input wire logic clk_i,         // clock
    input wire logic rst_i,         // synchronous reset
    input wire logic line_i,        // external line level
    input wire logic rising_sel_i,  // 1 rising, 0 falling
    output logic event_o            // one-cycle edge pulse
);
    logic prev;

    // prev resets high-inactive guess avoided: reset to line level
    // would need a port value, so a pulse right after reset is masked
    logic armed;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prev <= 1'b0;
            armed <= 1'b0;
        end
        else
        begin
            prev <= line_i;
            armed <= 1'b1;
        end
    end

    assign event_o = armed & (line_i != prev) & (line_i == rising_sel_i);
endmodule

// File: verif/tlpic_chk.sv
// port-level assertions for the priority interrupt controller
`timescale 1ns/100ps
module tlpic_chk (
    input wire logic clk_i,                   // clock
    input wire logic rst_i,                   // reset
    input wire logic [7:0] wb_adr_i,          // address
    input wire logic [31:0] wb_dat_i,         // write data
    input wire logic [31:0] wb_dat_o,         // read data
    input wire logic wb_we_i,                 // write enable
    input wire logic [3:0] wb_sel_i,          // selects
    input wire logic wb_cyc_i,                // cycle
    input wire logic wb_stb_i,                // strobe
    input wire logic wb_ack_o,                // ack
    input wire logic [2:0] ext_line_i,        // lines
    input wire logic [3:0] port_b_pins_i,     // pins
    input wire logic [7:0] port_b_latch_i,    // latch
    input wire logic timer_zero_overflow_i,   // timer
    input wire logic periph_high_req_i,       // high req
    input wire logic periph_low_req_i,        // low req
    input wire logic return_from_isr_instr_i, // return
    input wire logic pc_load_o,               // load
    input wire logic push_return_o,           // push
    input wire logic [20:0] pc_vector_o,      // vector
    input wire logic [7:0] port_pullup_en_o   // pull-ups
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_push_with_load: assert property (push_return_o == pc_load_o)
        else $error("push and vector load apart");
    a_vector_legal: assert property (pc_load_o |-> pc_vector_o inside {21'h8, 21'h18})
        else $error("vector address not legal");
    a_vector_holds: assert property (!pc_load_o |-> $stable(pc_vector_o))
        else $error("vector moved without a load");
    a_load_spacing: assert property (pc_load_o |=> !pc_load_o [*3])
        else $error("vector loads too close");
    a_reset_quiet: assert property ($fell(rst_i) |-> !pc_load_o [*4])
        else $error("vector load with globals off after reset");
    a_pullup_latch: assert property (port_pullup_en_o != 8'h0 |->
        port_pullup_en_o == $past(port_b_latch_i)) else $error("pull-ups not from latch");
endmodule

// File: verif/tlpic_cpu_model.sv
// cpu sequencer stand-in: tracks nesting, issues returns on request
`timescale 1ns/100ps
module tlpic_cpu_model (
    input wire logic clk_i,      // clock
    input wire logic rst_i,      // reset
    input wire logic pc_load_i,  // vector load
    input wire logic push_i,     // return push
    input wire logic ret_req_i,  // bench asks for a return
    output logic return_o,       // return pulse
    output logic [3:0] depth_o   // nesting depth
);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            depth_o <= 4'h0;
            return_o <= 1'b0;
        end
        else
        begin
            // no return without a routine entered first
            return_o <= ret_req_i && (depth_o != 4'h0);
            depth_o <= depth_o + {3'h0, pc_load_i & push_i} - {3'h0, return_o};
        end
    end
endmodule

// File: verif/tb_top.sv
// self-checking bench for the priority interrupt controller
`timescale 1ns/100ps
`include "tlpic_consts.svh"
module tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0, tmr = 1'b0;
    logic ph = 1'b0, pl = 1'b0, ret_req = 1'b0, ack, load, push, ret;
    logic [7:0] adr = 8'h0, latch = 8'h0, pu;
    logic [31:0] dat = 32'h0, dat_o, r;
    logic [3:0] sel = 4'h0, pins = 4'h0, depth;
    logic [2:0] ext = 3'h0;
    logic [20:0] vec, got;
    int bad_count = 0, samples_checked = 0, seed = 16, n;
    tlpic_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(ack), .ext_line_i(ext), .port_b_pins_i(pins), .port_b_latch_i(latch),
        .timer_zero_overflow_i(tmr), .periph_high_req_i(ph), .periph_low_req_i(pl),
        .return_from_isr_instr_i(ret), .pc_load_o(load), .push_return_o(push),
        .pc_vector_o(vec), .port_pullup_en_o(pu));
    tlpic_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .pc_load_i(load), .push_i(push),
        .ret_req_i(ret_req), .return_o(ret), .depth_o(depth));
    initial
        forever #2.5 clk_i = ~clk_i;
    task give_verdict;
        if (bad_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk_i);
        adr <= a;
        we <= w;
        dat <= {24'h0, d};
        sel <= 4'h1;
        cyc <= 1'b1;
        stb <= 1'b1;
        do
            @(posedge clk_i);
        while (ack !== 1'b1);
        r = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        bus(a, 1'b0, 8'h0);
        chk($sformatf("register %h", a), {24'h0, e}, r);
    endtask
    // 21'h1fffff stands for no vector load in the window
    task vec_wait(input logic [20:0] e);
        got = 21'h1fffff;
        repeat (10)
        begin
            @(posedge clk_i);
            if (load === 1'b1)
                got = vec;
        end
        chk("vector", {11'h0, e}, {11'h0, got});
    endtask
    task ret_pulse;
        @(posedge clk_i);
        ret_req <= 1'b1;
        @(posedge clk_i);
        ret_req <= 1'b0;
    endtask
    task edge_a;
        ext[0] <= 1'b0;
        @(posedge clk_i);
        ext[0] <= 1'b1;
    endtask
    initial
    begin
        #100000;
        bad_count++;
        give_verdict;
    end
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`TLPIC_OFS_MAIN, `TLPIC_RST_MAIN);
        rd(`TLPIC_OFS_EDGE, `TLPIC_RST_EDGE);
        rd(`TLPIC_OFS_EXT, `TLPIC_RST_EXT);
        rd(`TLPIC_OFS_RCTL, 8'h0);
        rd(8'h20, 8'h0);
        repeat (4)
        begin
            n = $random(seed);
            bus(`TLPIC_OFS_EXT, 1'b1, n[7:0]);
            rd(`TLPIC_OFS_EXT, n[7:0] & `TLPIC_MASK_EXT);
            bus(`TLPIC_OFS_EDGE, 1'b1, n[15:8]);
            rd(`TLPIC_OFS_EDGE, n[15:8] & `TLPIC_MASK_EDGE);
        end
        bus(`TLPIC_OFS_EDGE, 1'b1, 8'h70);
        latch <= n[23:16];
        rd(8'h20, 8'h0);
        chk("pull-up", {24'h0, n[23:16]}, {24'h0, pu});
        bus(`TLPIC_OFS_EDGE, 1'b1, 8'hf0);
        rd(8'h20, 8'h0);
        chk("pull-up", 32'h0, {24'h0, pu});
        for (int e = 0; e < 2; e++)
        begin
            ext <= {3{e[0]}};
            bus(`TLPIC_OFS_EDGE, 1'b1, {1'b0, {3{e[0]}}, 4'h0});
            bus(`TLPIC_OFS_MAIN, 1'b1, 8'h0);
            bus(`TLPIC_OFS_EXT, 1'b1, 8'h0);
            ext <= {3{~e[0]}};
            repeat (2) @(posedge clk_i);
            rd(`TLPIC_OFS_MAIN, 8'h0);
            rd(`TLPIC_OFS_EXT, 8'h0);
            ext <= {3{e[0]}};
            repeat (2) @(posedge clk_i);
            rd(`TLPIC_OFS_MAIN, 8'h02);
            rd(`TLPIC_OFS_EXT, 8'h03);
        end
        tmr <= 1'b1;
        @(posedge clk_i);
        tmr <= 1'b0;
        rd(`TLPIC_OFS_MAIN, 8'h06);
        pins <= n[27:24] | 4'h1;
        repeat (2) @(posedge clk_i);
        // clearing while the mismatch lasts must not stick
        bus(`TLPIC_OFS_MAIN, 1'b1, 8'h0);
        rd(`TLPIC_OFS_MAIN, 8'h01);
        rd(`TLPIC_OFS_PORT, {n[27:24] | 4'h1, 4'h0});
        bus(`TLPIC_OFS_MAIN, 1'b1, 8'h0);
        rd(`TLPIC_OFS_MAIN, 8'h0);
        bus(`TLPIC_OFS_MAIN, 1'b1, 8'h90);
        edge_a;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (load !== 1'b1 && n < 20);
        chk("latency", 32'd5, n);
        chk("vector", 32'h8, {11'h0, vec});
        rd(`TLPIC_OFS_MAIN, 8'h12);
        bus(`TLPIC_OFS_MAIN, 1'b1, 8'h10);
        ret_pulse;
        rd(`TLPIC_OFS_MAIN, 8'h90);
        bus(`TLPIC_OFS_MAIN, 1'b1, 8'h80);
        pl <= 1'b1;
        vec_wait(21'h1fffff);
        bus(`TLPIC_OFS_MAIN, 1'b1, 8'hc0);
        vec_wait(`TLPIC_VEC_HIGH);
        rd(`TLPIC_OFS_MAIN, 8'h40);
        pl <= 1'b0;
        ret_pulse;
        bus(`TLPIC_OFS_RCTL, 1'b1, 8'h80);
        pl <= 1'b1;
        vec_wait(`TLPIC_VEC_LOW);
        rd(`TLPIC_OFS_MAIN, 8'h80);
        ph <= 1'b1;
        vec_wait(`TLPIC_VEC_HIGH);
        ph <= 1'b0;
        rd(`TLPIC_OFS_MAIN, 8'h0);
        bus(`TLPIC_OFS_MAIN, 1'b1, 8'hc0);
        vec_wait(21'h1fffff);
        ret_pulse;
        vec_wait(`TLPIC_VEC_LOW);
        bus(`TLPIC_OFS_MAIN, 1'b1, 8'h40);
        vec_wait(21'h1fffff);
        pl <= 1'b0;
        bus(`TLPIC_OFS_MAIN, 1'b1, 8'h90);
        edge_a;
        vec_wait(`TLPIC_VEC_HIGH);
        // source priority bits in priority mode: timer low, line c high
        bus(`TLPIC_OFS_MAIN, 1'b1, 8'h0);
        ret_pulse;
        bus(`TLPIC_OFS_MAIN, 1'b1, 8'he0);
        tmr <= 1'b1;
        @(posedge clk_i);
        tmr <= 1'b0;
        vec_wait(`TLPIC_VEC_LOW);
        bus(`TLPIC_OFS_EXT, 1'b1, 8'h90);
        ext[2] <= 1'b0;
        @(posedge clk_i);
        ext[2] <= 1'b1;
        vec_wait(`TLPIC_VEC_HIGH);
        // served high, in high routine, low routine still open below it
        rd(`TLPIC_OFS_STAT, 8'h07);
        give_verdict;
    end
endmodule
bind tlpic_top tlpic_chk chk (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ext_line_i(ext_line_i),
    .port_b_pins_i(port_b_pins_i), .port_b_latch_i(port_b_latch_i),
    .timer_zero_overflow_i(timer_zero_overflow_i), .periph_high_req_i(periph_high_req_i),
    .periph_low_req_i(periph_low_req_i), .return_from_isr_instr_i(return_from_isr_instr_i),
    .pc_load_o(pc_load_o), .push_return_o(push_return_o), .pc_vector_o(pc_vector_o),
    .port_pullup_en_o(port_pullup_en_o));
